/* src/mdc_pkg.sv */
// Constants for the metering calibration register bank: word indices,
// field positions, reset values and the read framing of each word.
// Assumes an APB slave where byte address = 4 * word index.
// Behaviour
// - Phase C fundamental active offset: signed 24-bit read/write word, resets zero.
// - Six fundamental reactive gain/offset words for phases A-C, consecutive, zero.
// - Apparent threshold is 48 bits: lower index upper half, next lower half.
// - Active threshold is 48 bits from upper word then lower word.
// - Reactive threshold is 48 bits from upper word then lower word.
// - Three signed no-load thresholds: apparent, active, reactive, consecutive.
// - Signed fundamental power level word, read/write, resets zero.
// - Unsigned high-pass disable word for current channels, resets zero.
// - Signed current-sum mismatch threshold word.
// - Sign-extended words read as 32 bits: top four zero, 27:24 sign.
// - Zero-padded words read as 32 bits with upper eight bits zero.
package mdc_pkg;
   // Word indices as printed
   localparam logic [15:0] IDX_PHC_FA_OS   = 16'h43A2;
   localparam logic [15:0] IDX_PHA_FR_GAIN = 16'h43A3;
   localparam logic [15:0] IDX_PHA_FR_OS   = 16'h43A4;
   localparam logic [15:0] IDX_PHB_FR_GAIN = 16'h43A5;
   localparam logic [15:0] IDX_PHB_FR_OS   = 16'h43A6;
   localparam logic [15:0] IDX_PHC_FR_GAIN = 16'h43A7;
   localparam logic [15:0] IDX_PHC_FR_OS   = 16'h43A8;
   localparam logic [15:0] IDX_APP_THR_HI  = 16'h43A9;
   localparam logic [15:0] IDX_APP_THR_LO  = 16'h43AA;
   localparam logic [15:0] IDX_ACT_THR_HI  = 16'h43AB;
   localparam logic [15:0] IDX_ACT_THR_LO  = 16'h43AC;
   localparam logic [15:0] IDX_REA_THR_HI  = 16'h43AD;
   localparam logic [15:0] IDX_REA_THR_LO  = 16'h43AE;
   localparam logic [15:0] IDX_RSVD_ZERO_A = 16'h43AF;
   localparam logic [15:0] IDX_APP_NOLOAD  = 16'h43B0;
   localparam logic [15:0] IDX_ACT_NOLOAD  = 16'h43B1;
   localparam logic [15:0] IDX_REA_NOLOAD  = 16'h43B2;
   localparam logic [15:0] IDX_FUND_LEVEL  = 16'h43B3;
   localparam logic [15:0] IDX_RSVD_NO_WR  = 16'h43B4;
   localparam logic [15:0] IDX_INTEG_COEF  = 16'h43B5;
   localparam logic [15:0] IDX_HPF_DISABLE = 16'h43B6;
   localparam logic [15:0] IDX_RSVD_ZERO_B = 16'h43B7;
   localparam logic [15:0] IDX_ISUM_LEVEL  = 16'h43B8;
   // Bank extent and word layout
   localparam int          NUM_WORDS  = 23;
   localparam int          WORD_W     = 24;
   localparam int          SIGN_POS   = 23;
   localparam int          ADDR_W     = 18;
   localparam logic [23:0] RESET_WORD = 24'h000000;
   localparam logic [31:0] READ_ZERO  = 32'h00000000;
   localparam logic [3:0]  FRAME_TOP  = 4'h0;
   localparam logic [7:0]  PAD_ZP     = 8'h00;
   // Read framing selectors
   typedef enum logic [1:0] {
      MDC_FR_SE   = 2'h0,
      MDC_FR_ZP   = 2'h1,
      MDC_FR_RSVD = 2'h2
   } mdc_frame_t;
endpackage : mdc_pkg

/* src/mdc_regs.sv */
// Calibration and threshold register bank of the metering DSP, reached
// over APB; every word except the three reserved ones also drives an output toward the datapath.
// Assumes an APB master that holds its request until pready is seen.
// Assumes one clock and a synchronous reset; inputs are synchronous.
// Trade-off: a fixed single wait state keeps the handshake simple at
// the price of one extra cycle on every access.
// The datapath that consumes these words lives outside this block.
`timescale 1ns/1ps
`default_nettype none
module mdc_regs #(
   parameter int NWORDS = mdc_pkg::NUM_WORDS
) (
   input  wire logic                    core_clk,
   input  wire logic                    reset,
   // APB slave side
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [mdc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Calibration words toward the datapath
   output logic [23:0]                  phc_fund_active_offset,
   output logic [23:0]                  pha_fund_reactive_gain,
   output logic [23:0]                  pha_fund_reactive_offset,
   output logic [23:0]                  phb_fund_reactive_gain,
   output logic [23:0]                  phb_fund_reactive_offset,
   output logic [23:0]                  phc_fund_reactive_gain,
   output logic [23:0]                  phc_fund_reactive_offset,
   // 48-bit thresholds, high word first
   output logic [47:0]                  apparent_accum_threshold,
   output logic [47:0]                  active_accum_threshold,
   output logic [47:0]                  reactive_accum_threshold,
   // No-load, level, coefficient, filter and mismatch words
   output logic [23:0]                  apparent_noload_level,
   output logic [23:0]                  active_noload_level,
   output logic [23:0]                  reactive_noload_level,
   output logic [23:0]                  fund_power_level,
   output logic [23:0]                  integrator_coefficient,
   output logic [23:0]                  highpass_disable,
   output logic [23:0]                  current_sum_mismatch_level
);

   // Bus handshake states, one-hot
   // Only two states: idle waits for an access, ack answers once
   typedef enum logic [1:0] {
      MDC_ST_IDLE = 2'b01,
      MDC_ST_ACK  = 2'b10
   } mdc_state_t;

   // All state of the bank in one word
   // Reserved slots stay in the array so the slot is a plain
   // subtraction; their flops are never written.
   typedef struct packed {
      mdc_state_t               state;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic [NWORDS-1:0][23:0]  cfg;
   } mdc_regs_t;

   mdc_regs_t st_reg;
   mdc_regs_t st_next;

   // Address decode results
   logic        word_aligned;
   logic        in_bank;
   logic [15:0] word_idx;
   logic [15:0] rel_idx;
   logic [4:0]  slot;
   mdc_pkg::mdc_frame_t frame;
   logic [23:0] cur_word;
   logic [31:0] read_word;

   // Word index from the byte address
   // Misaligned or out-of-range addresses are flagged here and
   // answered with an error; the slot is then never used to store.
   // The slot is only meaningful while in_bank is high, since the
   // subtraction wraps for indices below the bank.
   always_comb
   begin
      word_idx     = paddr[mdc_pkg::ADDR_W-1:2];
      rel_idx      = word_idx - mdc_pkg::IDX_PHC_FA_OS;
      word_aligned = (paddr[1:0] == 2'h0);
      in_bank      = word_aligned
                     && (word_idx >= mdc_pkg::IDX_PHC_FA_OS)
                     && (word_idx <= mdc_pkg::IDX_ISUM_LEVEL);
      slot         = rel_idx[4:0];
   end

   // Framing of each word on a read
   always_comb
   begin
      case (word_idx)
         mdc_pkg::IDX_APP_THR_HI,
         mdc_pkg::IDX_APP_THR_LO,
         mdc_pkg::IDX_ACT_THR_HI,
         mdc_pkg::IDX_ACT_THR_LO,
         mdc_pkg::IDX_REA_THR_HI,
         mdc_pkg::IDX_REA_THR_LO,
         mdc_pkg::IDX_HPF_DISABLE:
            frame = mdc_pkg::MDC_FR_ZP;
         mdc_pkg::IDX_RSVD_ZERO_A,
         mdc_pkg::IDX_RSVD_NO_WR,
         mdc_pkg::IDX_RSVD_ZERO_B:
            frame = mdc_pkg::MDC_FR_RSVD;
         mdc_pkg::IDX_PHC_FA_OS,
         mdc_pkg::IDX_PHA_FR_GAIN,
         mdc_pkg::IDX_PHA_FR_OS,
         mdc_pkg::IDX_PHB_FR_GAIN,
         mdc_pkg::IDX_PHB_FR_OS,
         mdc_pkg::IDX_PHC_FR_GAIN,
         mdc_pkg::IDX_PHC_FR_OS,
         mdc_pkg::IDX_APP_NOLOAD,
         mdc_pkg::IDX_ACT_NOLOAD,
         mdc_pkg::IDX_REA_NOLOAD,
         mdc_pkg::IDX_FUND_LEVEL,
         mdc_pkg::IDX_INTEG_COEF,
         mdc_pkg::IDX_ISUM_LEVEL:
            frame = mdc_pkg::MDC_FR_SE;
         // Unmapped indices: framing is moot, data is forced to zero
         default:
            frame = mdc_pkg::MDC_FR_SE;
      endcase
   end

   // Read data as it travels on the link
   // Unmapped reads see the reset word so no stale slot leaks out;
   // the error flag tells the host the data is meaningless.
   always_comb
   begin
      cur_word = in_bank ? st_reg.cfg[slot] : mdc_pkg::RESET_WORD;
      case (frame)
         mdc_pkg::MDC_FR_SE:
            read_word = {mdc_pkg::FRAME_TOP,
                         {4{cur_word[mdc_pkg::SIGN_POS]}},
                         cur_word};
         mdc_pkg::MDC_FR_ZP:
            read_word = {mdc_pkg::PAD_ZP, cur_word};
         default:
            read_word = mdc_pkg::READ_ZERO; // Reserved words
      endcase
   end

   // Handshake and register update
   // One wait state: pready rises the cycle after the first access
   // cycle, and the write lands on that same completing edge.
   always_comb
   begin
      st_next = st_reg;
      case (st_reg.state)
         MDC_ST_IDLE:
         begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            // Take the request on the first access cycle only; the
            // setup cycle alone never starts an answer, so a master
            // that parks psel high causes no stray ready.
            if (psel && penable)
            begin
               st_next.state   = MDC_ST_ACK;
               st_next.pready  = 1'b1;
               st_next.pslverr = !in_bank;
               st_next.prdata  = (!pwrite && in_bank) ? read_word
                                 : mdc_pkg::READ_ZERO;
            end
         end
         MDC_ST_ACK:
         begin
            st_next.state   = MDC_ST_IDLE;
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.prdata  = mdc_pkg::READ_ZERO;
            // The master still holds address, direction and data on
            // this completing edge, so they are safe to use here.
            // Reserved words are never stored, so they stay zero
            // even if a host breaks the keep-zero convention.
            if (pwrite && in_bank
                && (frame != mdc_pkg::MDC_FR_RSVD))
            begin
               // Only the 24 data bits land; framing bits dropped
               // Lane 3 carries only framing, so its strobe is moot;
               // a partial write keeps the untouched lanes.
               if (pstrb[0])
                  st_next.cfg[slot][7:0]   = pwdata[7:0];
               if (pstrb[1])
                  st_next.cfg[slot][15:8]  = pwdata[15:8];
               if (pstrb[2])
                  st_next.cfg[slot][23:16] = pwdata[23:16];
            end
         end
         // Illegal code: fall back to idle without an answer
         default:
         begin
            st_next.state   = MDC_ST_IDLE;
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
         end
      endcase
   end

   // State register, synchronous reset
   // Every word returns to zero, so a read after reset sees zero
   // until the host writes again.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         st_reg.state   <= MDC_ST_IDLE;
         st_reg.pready  <= 1'b0;
         st_reg.pslverr <= 1'b0;
         st_reg.prdata  <= mdc_pkg::READ_ZERO;
         for (int i = 0; i < NWORDS; i++)
            st_reg.cfg[i] <= mdc_pkg::RESET_WORD;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Bus outputs straight from flops
   // Read data is zero whenever pready is low
   assign pready  = st_reg.pready;
   assign prdata  = st_reg.prdata;
   assign pslverr = st_reg.pslverr;

   // Slot map: slot = word index - 0x43A2
   // slot  0  0x43A2  phase C fundamental active offset
   // slot  1  0x43A3  phase A fundamental reactive gain
   // slot  2  0x43A4  phase A fundamental reactive offset
   // slot  3  0x43A5  phase B fundamental reactive gain
   // slot  4  0x43A6  phase B fundamental reactive offset
   // slot  5  0x43A7  phase C fundamental reactive gain
   // slot  6  0x43A8  phase C fundamental reactive offset
   // slot  7  0x43A9  apparent threshold, high word
   // slot  8  0x43AA  apparent threshold, low word
   // slot  9  0x43AB  active threshold, high word
   // slot 10  0x43AC  active threshold, low word
   // slot 11  0x43AD  reactive threshold, high word
   // slot 12  0x43AE  reactive threshold, low word
   // slot 13  0x43AF  reserved, keep zero
   // slot 14  0x43B0  apparent no-load level
   // slot 15  0x43B1  active no-load level
   // slot 16  0x43B2  reactive no-load level
   // slot 17  0x43B3  fundamental power level
   // slot 18  0x43B4  reserved, never written
   // slot 19  0x43B5  integrator coefficient
   // slot 20  0x43B6  high-pass disable
   // slot 21  0x43B7  reserved, keep zero
   // slot 22  0x43B8  current-sum mismatch level
   // Reserved slots are never stored, so their flops hold the
   // reset word and synthesis may trim them.

   // Fundamental active and reactive calibration words
   // Slot 0: phase C active offset
   assign phc_fund_active_offset   =
      st_reg.cfg[0];

   // Slot 1: phase A reactive gain
   assign pha_fund_reactive_gain   =
      st_reg.cfg[1];

   // Slot 2: phase A reactive offset
   assign pha_fund_reactive_offset =
      st_reg.cfg[2];

   // Slot 3: phase B reactive gain
   assign phb_fund_reactive_gain   =
      st_reg.cfg[3];

   // Slot 4: phase B reactive offset
   assign phb_fund_reactive_offset =
      st_reg.cfg[4];

   // Slot 5: phase C reactive gain
   assign phc_fund_reactive_gain   =
      st_reg.cfg[5];

   // Slot 6: phase C reactive offset
   assign phc_fund_reactive_offset =
      st_reg.cfg[6];

   // 48-bit thresholds: lower index is the upper half
   // The halves are written one at a time, so the datapath may see
   // a mixed value for one access; hosts write both halves at rest.
   // Slots 7 and 8: apparent threshold
   assign apparent_accum_threshold =
      {st_reg.cfg[7], st_reg.cfg[8]};

   // Slots 9 and 10: active threshold
   assign active_accum_threshold   =
      {st_reg.cfg[9], st_reg.cfg[10]};

   // Slots 11 and 12: reactive threshold
   assign reactive_accum_threshold =
      {st_reg.cfg[11], st_reg.cfg[12]};

   // No-load thresholds, slot 13 is reserved
   // Slot 14: apparent no-load level
   assign apparent_noload_level =
      st_reg.cfg[14];

   // Slot 15: active no-load level
   assign active_noload_level   =
      st_reg.cfg[15];

   // Slot 16: reactive no-load level
   assign reactive_noload_level =
      st_reg.cfg[16];

   // Level, coefficient, filter and mismatch words
   // Slot 17: fundamental power level
   assign fund_power_level           =
      st_reg.cfg[17];

   // Slot 19: stored as written; datapath expects the FF8000 setting
   assign integrator_coefficient     =
      st_reg.cfg[19];

   // Slot 20: high-pass disable, unsigned
   assign highpass_disable           =
      st_reg.cfg[20];

   // Slot 22: current-sum mismatch level
   assign current_sum_mismatch_level =
      st_reg.cfg[22];

   // Limitation: no write protection beyond the reserved slots; a
   // host may load any value into the calibration words.

endmodule : mdc_regs
`default_nettype wire

/* sim/mdc_regs_chk.sv */
// Assertions on the APB pins and two word outputs of the bank.
// Bound into mdc_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mdc_regs_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [47:0] apparent_accum_threshold,
   input wire logic [23:0] highpass_disable
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // Word index, stored data slice and framing class of the bus address
   logic [15:0] ix;
   logic [23:0] wd;
   logic        zp;
   logic        rsv;
   assign ix = paddr[17:2];
   assign wd = pwdata[23:0];
   assign zp = ix inside {[16'h43A9:16'h43AE], 16'h43B6};
   assign rsv = ix inside {16'h43AF, 16'h43B4, 16'h43B7};
   sequence s_rd; pready && !pwrite && !pslverr; endsequence
   sequence s_wr; pready && pwrite && !pslverr && pstrb == 4'hF; endsequence
   property p_lat; $rose(penable) && psel |=> pready; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_idle; !(psel && penable) |=> !pready; endproperty
   property p_quiet; !pready |-> prdata == 32'h00000000 && !pslverr;
   endproperty
   property p_se; s_rd ##0 !zp |->
      prdata[31:28] == 4'h0 && prdata[27:24] == {4{prdata[23]}};
   endproperty
   property p_zp; s_rd ##0 zp |-> prdata[31:24] == 8'h00; endproperty
   property p_rsv; s_rd ##0 rsv |-> prdata == 32'h00000000; endproperty
   property p_hpf; s_wr ##0 ix == 16'h43B6 |=> highpass_disable == $past(wd);
   endproperty
   property p_thr; s_wr ##0 ix == 16'h43A9 |=>
      apparent_accum_threshold[47:24] == $past(wd);
   endproperty
   a_lat: assert property (p_lat) else $error("late answer");
   a_one: assert property (p_one) else $error("long ready");
   a_idle: assert property (p_idle) else $error("stray ready");
   a_quiet: assert property (p_quiet) else $error("data off");
   a_se: assert property (p_se) else $error("bad sign frame");
   a_zp: assert property (p_zp) else $error("bad pad frame");
   a_rsv: assert property (p_rsv) else $error("reserved nonzero");
   a_hpf: assert property (p_hpf) else $error("hpf not stored");
   a_thr: assert property (p_thr) else $error("thr not stored");
endmodule : mdc_regs_chk
bind mdc_regs mdc_regs_chk i_chk (.core_clk(core_clk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .apparent_accum_threshold(apparent_accum_threshold),
   .highpass_disable(highpass_disable));
`default_nettype wire

/* sim/mdc_host.sv */
// Host model: APB master in place of the serial-port host.
// Driven by the bench through xfer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module mdc_host (
   input  wire logic        core_clk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [17:0] paddr,
   output var  logic [31:0] pwdata,
   output var  logic [3:0]  pstrb,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h00000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
   end
   // One transfer; gap + 1 idle cycles before setup, so a larger gap makes a slow host
   task automatic xfer(input logic w, input logic [17:0] a,
      input logic [31:0] d, input logic [3:0] s, input int gap,
      output logic [31:0] rd, output logic err);
      rd = 'x;
      err = 1'bx;
      // Keep-zero words only get zero; the no-write word never a write
      if (w && (a[17:2] == 16'h43B4 || (d != 0 &&
         a[17:2] inside {16'h43AF, 16'h43B7})))
         return;
      repeat (gap + 1) @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      // Wait for the answer; only the bench watchdog ends a hang
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // Released address and data flip so stale values cannot pass
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : mdc_host
`default_nettype wire

/* sim/test_metering_dsp_calibration_regs.sv */
// Self-checking bench for the calibration register bank.
// Host model drives APB; the checker is bound to the bank.
`timescale 1ns/1ps
`default_nettype none
module test_metering_dsp_calibration_regs;
   logic              core_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [17:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic              err;
   logic [23:0]       fa_os, highpass_filter, coef;
   wire logic [2:0][47:0] thr;
   wire logic [10:0][23:0] wo;
   int                n_mismatch = 0;
   int                checked = 0;
   // 250 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   mdc_regs i_dut (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .phc_fund_active_offset(fa_os), .pha_fund_reactive_gain(wo[0]),
      .pha_fund_reactive_offset(wo[1]), .phb_fund_reactive_gain(wo[2]),
      .phb_fund_reactive_offset(wo[3]), .phc_fund_reactive_gain(wo[4]),
      .phc_fund_reactive_offset(wo[5]), .apparent_accum_threshold(thr[0]),
      .active_accum_threshold(thr[1]), .reactive_accum_threshold(thr[2]),
      .apparent_noload_level(wo[6]), .active_noload_level(wo[7]),
      .reactive_noload_level(wo[8]), .fund_power_level(wo[9]),
      .integrator_coefficient(coef), .highpass_disable(highpass_filter),
      .current_sum_mismatch_level(wo[10]));
   mdc_host i_host (.core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Expected read word: reserved zero, pad or sign framing
   function automatic logic [31:0] fr(input logic [15:0] i,
      input logic [23:0] d);
      if (i inside {16'h43AF, 16'h43B4, 16'h43B7})
         return 32'h00000000;
      if (i inside {[16'h43A9:16'h43AE], 16'h43B6})
         return {8'h00, d};
      return {4'h0, {4{d[23]}}, d};
   endfunction : fr
   function automatic logic [23:0] pat(input logic [15:0] i);
      return {(i[0] ? 8'hC3 : 8'h3C), i};
   endfunction : pat
   task automatic acc(input logic w, input logic [15:0] i,
      input logic [31:0] d, input logic [3:0] s);
      i_host.xfer(w, {i, 2'b00}, d, s, 0, rd, err);
   endtask : acc
   task automatic t_zero;
      for (int k = 16'h43A2; k <= 16'h43B8; k++)
      begin
         acc(1'b0, k[15:0], 32'h00000000, 4'h0);
         chk({err, rd}, 48'h0);
      end
      chk(highpass_filter, 24'h000000);
   endtask : t_zero
   task automatic t_rw_all;
      for (int k = 16'h43A2; k <= 16'h43B8; k++)
         acc(1'b1, k[15:0], {8'hEE, pat(k[15:0])}, 4'hF);
      for (int k = 16'h43A2; k <= 16'h43B8; k++)
      begin
         acc(1'b0, k[15:0], 32'h00000000, 4'h0);
         chk(rd, fr(k[15:0], pat(k[15:0])));
      end
      // Word outputs toward the datapath
      for (int m = 0; m < 11; m++)
         chk(wo[m], pat(m < 6 ? 16'h43A3 + 16'(m) : m < 10 ?
            16'h43AA + 16'(m) : 16'h43B8));
      chk(fa_os, pat(16'h43A2));
      chk(coef, pat(16'h43B5));
   endtask : t_rw_all
   task automatic t_thr;
      for (int j = 0; j < 3; j++)
      begin
         acc(1'b1, 16'h43A9 + 16'(2 * j), 32'h00800000 + j, 4'hF);
         acc(1'b1, 16'h43AA + 16'(2 * j), 32'h00FFFFFF - j, 4'hF);
         @(posedge core_clk);
         chk(thr[j], {24'h800000 + 24'(j), 24'hFFFFFF - 24'(j)});
      end
   endtask : t_thr
   task automatic t_coef_strb;
      acc(1'b1, 16'h43B5, 32'h00FF8000, 4'hF);
      acc(1'b0, 16'h43B5, 32'h00000000, 4'h0);
      chk(rd, 32'h0FFF8000);
      chk(coef, 24'hFF8000);
      acc(1'b1, 16'h43A2, 32'hAB123456, 4'hF);
      acc(1'b1, 16'h43A2, 32'h000000FF, 4'h1);
      acc(1'b0, 16'h43A2, 32'h00000000, 4'h0);
      chk(rd, 32'h001234FF);
      chk(fa_os, 24'h1234FF);
   endtask : t_coef_strb
   // Misaligned and unmapped places, from a slow host
   task automatic t_err;
      i_host.xfer(1'b1, {16'h43B6, 2'b10}, 32'h1, 4'hF, 3, rd, err);
      chk({err, rd}, {1'b1, 32'h0});
      i_host.xfer(1'b1, {16'h43B9, 2'b00}, 32'h1, 4'hF, 3, rd, err);
      chk(err, 1'b1);
      acc(1'b1, 16'h43AF, 32'h00000000, 4'hF);
      acc(1'b0, 16'h43B6, 32'h00000000, 4'h0);
      chk({err, rd}, {8'h00, pat(16'h43B6)});
   endtask : t_err
   task automatic report_and_stop;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // Main sequence, with a second reset in mid-run
   initial
   begin
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      t_zero;
      t_rw_all;
      t_thr;
      t_coef_strb;
      t_err;
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      t_zero;
      report_and_stop;
   end
   // Watchdog against a hung bus
   initial
   begin
      #40000;
      n_mismatch++;
      report_and_stop;
   end
endmodule : test_metering_dsp_calibration_regs
`default_nettype wire
